// ---- hw/scs_sysclk_standby.sv ----
// Design: system clock selection and standby controller
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// -----------------------------------------------------------------------------
module scs_sysclk_standby
  import sysclk_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       srst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrStb,
  input  wire logic       regRdStb,
  output logic      [7:0] regRdData_ff,
  input  wire logic       mainOscTick,
  input  wire logic       subOscTick,
  input  wire logic [7:0] opcode,
  input  wire logic       opcodeValid,
  input  wire logic       standbyInhibit,
  input  wire logic       wake_pin,
  input  wire logic       irqRelease,
  input  wire logic       timeBaseOvf,
  input  wire logic       time_base_request_flag,
  input  wire logic       watchdogFitted,
  output logic            sysClkTick_ff,
  output logic            mainOscRun_ff,
  output logic            coreStall_ff,
  output logic            haltActive_ff,
  output logic            holdActive_ff,
  output logic            irqEnableClr_ff,
  output logic            irqRequestClr_ff,
  output logic            watchdogReset_ff,
  output logic            switchBusy_ff
);

  // ---------------------------------------------------------------------------
  // Pin synchronisers: the first stage feeds only the second
  // ---------------------------------------------------------------------------
  logic       pinMeta_ff;
  logic       pinSync_ff;
  logic       mainTickMeta_ff;
  logic       mainTickSync_ff;
  logic       mainTickOld_ff;
  logic       subTickMeta_ff;
  logic       subTickSync_ff;
  logic       subTickOld_ff;
  logic       mainEdge;
  logic       subEdge;

  // Oscillator inputs are asynchronous levels; edges are found after sync
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      pinMeta_ff      <= 1'b0;
      pinSync_ff      <= 1'b0;
      mainTickMeta_ff <= 1'b0;
      mainTickSync_ff <= 1'b0;
      mainTickOld_ff  <= 1'b0;
      subTickMeta_ff  <= 1'b0;
      subTickSync_ff  <= 1'b0;
      subTickOld_ff   <= 1'b0;
    end
    else
    begin
      pinMeta_ff      <= wake_pin;
      pinSync_ff      <= pinMeta_ff;
      mainTickMeta_ff <= mainOscTick;
      mainTickSync_ff <= mainTickMeta_ff;
      mainTickOld_ff  <= mainTickSync_ff;
      subTickMeta_ff  <= subOscTick;
      subTickSync_ff  <= subTickMeta_ff;
      subTickOld_ff   <= subTickSync_ff;
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  logic [1:0] clock_select_field_ff;
  logic       main_osc_stop_flag_ff;
  logic       deep_sleep_select_ff;
  logic       hold_pin_wake_enable_ff;
  logic       halt_pin_wake_enable_ff;
  logic       halt_interrupt_wake_enable_ff;

  // Main edges count only while the main oscillator is enabled; sub edges always count
  assign mainEdge = mainTickSync_ff & ~mainTickOld_ff & ~main_osc_stop_flag_ff;
  assign subEdge  = subTickSync_ff & ~subTickOld_ff;

  // Software writes; reset puts the core on main divided by 32
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      clock_select_field_ff         <= SCS_CLKSEL_RST;
      main_osc_stop_flag_ff         <= SCS_OSCSTOP_RST;
      deep_sleep_select_ff          <= SCS_STBY_RST[SCS_SLEEP_BIT];
      hold_pin_wake_enable_ff       <= SCS_STBY_RST[SCS_HOLDPIN_BIT];
      halt_pin_wake_enable_ff       <= SCS_STBY_RST[SCS_HALTPIN_BIT];
      halt_interrupt_wake_enable_ff <= SCS_STBY_RST[SCS_HALTIRQ_BIT];
    end
    else if (regWrStb && regAddr == SCS_ADDR_CLKCTL)
    begin
      clock_select_field_ff <= regWrData[SCS_CLKSEL_LSB +: 2];
      main_osc_stop_flag_ff <= regWrData[SCS_OSCSTOP_BIT];
    end
    else if (regWrStb && regAddr == SCS_ADDR_STBYCTL)
    begin
      deep_sleep_select_ff          <= regWrData[SCS_SLEEP_BIT];
      hold_pin_wake_enable_ff       <= regWrData[SCS_HOLDPIN_BIT];
      halt_pin_wake_enable_ff       <= regWrData[SCS_HALTPIN_BIT];
      halt_interrupt_wake_enable_ff <= regWrData[SCS_HALTIRQ_BIT];
    end
  end

  // ---------------------------------------------------------------------------
  // Clock changeover: the active source follows the field after 64 main ticks
  // ---------------------------------------------------------------------------
  scs_src_e   activeSrc_ff;
  logic [6:0] switchCnt_ff;
  logic       selWrite;

  assign selWrite = regWrStb && regAddr == SCS_ADDR_CLKCTL &&
                    regWrData[SCS_CLKSEL_LSB +: 2] != clock_select_field_ff;

  // Counting main ticks bounds the switch; a stopped oscillator would hang,
  // which is why software must keep it running while it changes mode
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      activeSrc_ff  <= SCS_SRC_DIV32;
      switchCnt_ff  <= 7'h00;
      switchBusy_ff <= 1'b0;
    end
    else if (selWrite)
    begin
      switchCnt_ff  <= SCS_SWITCH_CNT;
      switchBusy_ff <= 1'b1;
    end
    else if (switchBusy_ff && mainEdge)
    begin
      if (switchCnt_ff == 7'h01)
      begin
        activeSrc_ff  <= scs_src_e'(clock_select_field_ff);
        switchBusy_ff <= 1'b0;
      end
      switchCnt_ff <= switchCnt_ff - 7'h01;
    end
  end

  // ---------------------------------------------------------------------------
  // System clock tick generation from the active source
  // ---------------------------------------------------------------------------
  logic [4:0] divCnt_ff;
  logic       nxt_sysTick;
  scs_state_e pwrState_ff;
  scs_state_e nxt_pwrState;

  // Divider runs on main edges; the sub source bypasses it
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      divCnt_ff <= 5'h00;
    else if (mainEdge)
      divCnt_ff <= divCnt_ff + 5'h01;
  end

  always_comb
  begin
    case (activeSrc_ff)
      SCS_SRC_DIV1:  nxt_sysTick = mainEdge;
      SCS_SRC_DIV2:  nxt_sysTick = mainEdge & divCnt_ff[0];
      SCS_SRC_DIV32: nxt_sysTick = mainEdge & (divCnt_ff == SCS_DIV32_LAST);
      SCS_SRC_SUB:   nxt_sysTick = subEdge;
      default:       nxt_sysTick = 1'b0;
    endcase
  end

  // Follow the next state, so the tick stops on the very cycle the core stalls, and the main oscillator on the cycle HOLD begins
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      sysClkTick_ff <= 1'b0;
      mainOscRun_ff <= 1'b1;
    end
    else
    begin
      sysClkTick_ff <= nxt_sysTick & (nxt_pwrState == SCS_ST_RUN);
      mainOscRun_ff <= ~main_osc_stop_flag_ff & (nxt_pwrState != SCS_ST_HOLD);
    end
  end

  // ---------------------------------------------------------------------------
  // Standby state machine
  // ---------------------------------------------------------------------------
  scs_wake_s  wake;
  logic       tbPend_ff;
  logic       standbyExec;
  logic       wdPulse;

  assign wake.pin    = pinSync_ff;
  assign wake.irqRel = irqRelease;
  assign wake.tbOvf  = timeBaseOvf;
  assign wake.tbReq  = time_base_request_flag;

  // Inhibit makes the opcode a plain no-op
  assign standbyExec = opcodeValid && opcode == SCS_OP_STANDBY &&
                       !standbyInhibit;

  always_comb
  begin
    nxt_pwrState = pwrState_ff;
    wdPulse      = 1'b0;
    case (pwrState_ff)
      SCS_ST_RUN:
      begin
        if (standbyExec)
        begin
          if (deep_sleep_select_ff)
            nxt_pwrState = SCS_ST_HOLD;
          else
            nxt_pwrState = SCS_ST_HALT;
        end
      end
      SCS_ST_HALT:
      begin
        if ((wake.pin && halt_pin_wake_enable_ff) ||
            (wake.irqRel && halt_interrupt_wake_enable_ff) ||
            wake.tbOvf)
          nxt_pwrState = SCS_ST_RUN;
        // A flag pending at entry turns the overflow exit into a watchdog reset
        wdPulse = wake.tbOvf & tbPend_ff & watchdogFitted;
      end
      SCS_ST_HOLD:
      begin
        if (wake.pin && hold_pin_wake_enable_ff)
          nxt_pwrState = SCS_ST_RUN;
      end
      default:
        nxt_pwrState = SCS_ST_RUN;
    endcase
  end

  // Reset always wins and returns the core to run
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      pwrState_ff <= SCS_ST_RUN;
    else
      pwrState_ff <= nxt_pwrState;
  end

  // Latch the request flag as HALT begins; it holds until the core runs again
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      tbPend_ff <= 1'b0;
    else if (pwrState_ff == SCS_ST_RUN)
      tbPend_ff <= standbyExec & ~deep_sleep_select_ff & wake.tbReq;
  end

  // State outputs and one-cycle clear pulses on HOLD entry
  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      haltActive_ff    <= 1'b0;
      holdActive_ff    <= 1'b0;
      coreStall_ff     <= 1'b0;
      irqEnableClr_ff  <= 1'b0;
      irqRequestClr_ff <= 1'b0;
      watchdogReset_ff <= 1'b0;
    end
    else
    begin
      haltActive_ff    <= nxt_pwrState == SCS_ST_HALT;
      holdActive_ff    <= nxt_pwrState == SCS_ST_HOLD;
      coreStall_ff     <= nxt_pwrState != SCS_ST_RUN;
      irqEnableClr_ff  <= pwrState_ff == SCS_ST_RUN &&
                          nxt_pwrState == SCS_ST_HOLD;
      irqRequestClr_ff <= pwrState_ff == SCS_ST_RUN &&
                          nxt_pwrState == SCS_ST_HOLD;
      watchdogReset_ff <= wdPulse;
    end
  end

  // ---------------------------------------------------------------------------
  // Register read port: data stands the cycle after the strobe only
  // ---------------------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      regRdData_ff <= 8'h00;
    else if (regRdStb)
    begin
      case (regAddr)
        SCS_ADDR_CLKCTL:  regRdData_ff <= {5'h00, main_osc_stop_flag_ff,
                                           clock_select_field_ff};
        SCS_ADDR_STBYCTL: regRdData_ff <= {4'h0, halt_interrupt_wake_enable_ff,
                                           halt_pin_wake_enable_ff,
                                           hold_pin_wake_enable_ff,
                                           deep_sleep_select_ff};
        SCS_ADDR_STATUS:  regRdData_ff <= {2'h0, pwrState_ff, switchBusy_ff,
                                           pinSync_ff, activeSrc_ff};
        default:          regRdData_ff <= 8'h00;
      endcase
    end
    else
      regRdData_ff <= 8'h00;
  end

endmodule

// ---- inc/sysclk_pkg.sv ----
// Package: constants and carrier types for the system clock and standby controller
package sysclk_pkg;

  // ---------------------------------------------------------------------------
  // Register map (word addresses on the plain register port)
  // ---------------------------------------------------------------------------
  localparam logic [3:0] SCS_ADDR_CLKCTL  = 4'h0; // clock select and oscillator stop
  localparam logic [3:0] SCS_ADDR_STBYCTL = 4'h1; // deep sleep select and wake enables
  localparam logic [3:0] SCS_ADDR_STATUS  = 4'h2; // live state, read only

  // Field positions
  localparam int SCS_CLKSEL_LSB   = 0;
  localparam int SCS_OSCSTOP_BIT  = 2;
  localparam int SCS_SLEEP_BIT    = 0;
  localparam int SCS_HOLDPIN_BIT  = 1;
  localparam int SCS_HALTPIN_BIT  = 2;
  localparam int SCS_HALTIRQ_BIT  = 3;

  // Reset values
  localparam logic [1:0] SCS_CLKSEL_RST  = 2'h0;
  localparam logic       SCS_OSCSTOP_RST = 1'b0;
  localparam logic [3:0] SCS_STBY_RST    = 4'h0;

  // Standby opcode, one byte
  localparam logic [7:0] SCS_OP_STANDBY = 8'hF6;

  // Changeover timing, in main oscillator cycles
  localparam int SCS_SWITCH_MAIN_CYC = 64;
  localparam logic [6:0] SCS_SWITCH_CNT = 7'(SCS_SWITCH_MAIN_CYC);

  // Divider ratios
  localparam logic [4:0] SCS_DIV32_LAST = 5'h1F;

  // Clock source selection
  typedef enum logic [1:0] {
    SCS_SRC_DIV32 = 2'b00,
    SCS_SRC_DIV1  = 2'b01,
    SCS_SRC_DIV2  = 2'b10,
    SCS_SRC_SUB   = 2'b11
  } scs_src_e;

  // Power state
  typedef enum logic [1:0] {
    SCS_ST_RUN  = 2'b00,
    SCS_ST_HALT = 2'b01,
    SCS_ST_HOLD = 2'b10
  } scs_state_e;

  // Wake sources, grouped
  typedef struct packed {
    logic pin;      // wake pin level, synchronised
    logic irqRel;   // interrupt release request
    logic tbOvf;    // time base overflow pulse
    logic tbReq;    // time base request flag already set
  } scs_wake_s;

endpackage

// ---- dv/scs_sysclk_standby_properties.sv ----
// Checker: port timing relations of the clock and standby controller
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Checker module
// ---------------------------------------------------------------------------
module scs_sysclk_standby_properties
  import sysclk_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       srst,
  input wire logic [7:0] opcode,
  input wire logic       opcodeValid,
  input wire logic       standbyInhibit,
  input wire logic       wake_pin,
  input wire logic       timeBaseOvf,
  input wire logic       time_base_request_flag,
  input wire logic       watchdogFitted,
  input wire logic       sysClkTick_ff,
  input wire logic       mainOscRun_ff,
  input wire logic       coreStall_ff,
  input wire logic       haltActive_ff,
  input wire logic       holdActive_ff,
  input wire logic       irqEnableClr_ff,
  input wire logic       irqRequestClr_ff,
  input wire logic       watchdogReset_ff,
  input wire logic       switchBusy_ff
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  a_stall_mode: assert property (coreStall_ff == (haltActive_ff || holdActive_ff))
    else $error("stall does not match standby state");
  a_one_mode: assert property (!(haltActive_ff && holdActive_ff))
    else $error("halt and hold both active");
  a_standby_enter: assert property (opcodeValid && opcode == SCS_OP_STANDBY
    && !standbyInhibit && !coreStall_ff && !time_base_request_flag |=> coreStall_ff)
    else $error("standby opcode did not stall the core");
  a_inhibit_noop: assert property (opcodeValid && standbyInhibit && !coreStall_ff
    |=> !coreStall_ff)
    else $error("inhibited standby entered a low power state");
  a_halt_ovf_exit: assert property (haltActive_ff && timeBaseOvf |=> !haltActive_ff)
    else $error("time base overflow did not end halt");
  // Pin low long enough to have crossed the synchroniser keeps hold in place
  a_hold_stays: assert property ((!wake_pin [*4]) ##0 holdActive_ff |=> holdActive_ff)
    else $error("hold left without a pin wake");
  a_clear_pulse: assert property (irqEnableClr_ff |-> holdActive_ff && irqRequestClr_ff
    ##1 !irqEnableClr_ff)
    else $error("interrupt clear pulse outside hold entry");
  a_hold_osc_off: assert property (holdActive_ff |-> !mainOscRun_ff && !sysClkTick_ff)
    else $error("clocks still running in hold");
  a_wdog_cause: assert property (watchdogReset_ff |-> $past(haltActive_ff)
    && $past(timeBaseOvf) && $past(watchdogFitted))
    else $error("watchdog reset without an overflow exit from halt");
  a_switch_span: assert property ($rose(switchBusy_ff) |-> switchBusy_ff [*8]
    ##[1:1000] !switchBusy_ff)
    else $error("clock changeover length out of range");
endmodule

bind scs_sysclk_standby scs_sysclk_standby_properties u_chk (.clk_sys, .srst, .opcode,
  .opcodeValid, .standbyInhibit, .wake_pin, .timeBaseOvf, .time_base_request_flag,
  .watchdogFitted, .sysClkTick_ff, .mainOscRun_ff, .coreStall_ff, .haltActive_ff,
  .holdActive_ff, .irqEnableClr_ff, .irqRequestClr_ff, .watchdogReset_ff, .switchBusy_ff);

// ---- dv/scs_sysclk_standby_tb_top.sv ----
// Testbench: register, clock switch and standby scenarios for the controller
`timescale 1ns/1ps
module scs_sysclk_standby_tb_top
  import sysclk_pkg::*;
;
  // ---------------------------------------------------------------------------
  // Stimulus and observed signals
  // ---------------------------------------------------------------------------
  logic       clk_sys = 1'b0;
  logic       srst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic [7:0] opcode = 8'h00;
  logic [7:0] rdv;
  logic [7:0] regRdData_ff;
  logic       regWrStb = 1'b0, regRdStb = 1'b0, opcodeValid = 1'b0, standbyInhibit = 1'b0;
  logic       mainOscTick = 1'b0, subOscTick = 1'b0, wake_pin = 1'b0, irqRelease = 1'b0;
  logic       timeBaseOvf = 1'b0, tbReq = 1'b0, wdFit = 1'b0, clrSeen = 1'b0, wdSeen = 1'b0;
  logic       sysClkTick_ff, mainOscRun_ff, coreStall_ff, haltActive_ff, holdActive_ff;
  logic       irqEnableClr_ff, irqRequestClr_ff, watchdogReset_ff, switchBusy_ff;
  logic [3:0] subDiv = 4'h0;
  int         failCount = 0, comparisons = 0, cyc = 0, ticks = 0, i;

  scs_sysclk_standby dut (.clk_sys, .srst, .regAddr, .regWrData, .regWrStb, .regRdStb,
    .regRdData_ff, .mainOscTick, .subOscTick, .opcode, .opcodeValid, .standbyInhibit,
    .wake_pin, .irqRelease, .timeBaseOvf, .time_base_request_flag(tbReq),
    .watchdogFitted(wdFit), .sysClkTick_ff, .mainOscRun_ff, .coreStall_ff, .haltActive_ff,
    .holdActive_ff, .irqEnableClr_ff, .irqRequestClr_ff, .watchdogReset_ff, .switchBusy_ff);

  always #25 clk_sys = ~clk_sys;

  // Main cycle every 2 clocks, sub cycle every 16; pulse catchers and hang limit
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    mainOscTick <= ~mainOscTick;
    subDiv <= subDiv + 4'h1;
    subOscTick <= subDiv[3];
    if (sysClkTick_ff) ticks <= ticks + 1;
    if (irqEnableClr_ff && irqRequestClr_ff) clrSeen <= 1'b1;
    if (watchdogReset_ff) wdSeen <= 1'b1;
    if (cyc == 6000)
    begin
      failCount++;
      conclude();
    end
  end

  // ---------------------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk_sys);
    regWrStb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk_sys);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 rdv = regRdData_ff;
  endtask
  // Execute one instruction byte, then let the state settle for n cycles
  task automatic run_op(input logic [7:0] op, input int n);
    @(posedge clk_sys);
    opcode <= op;
    opcodeValid <= 1'b1;
    @(posedge clk_sys);
    opcodeValid <= 1'b0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic conclude();
    if (failCount == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    logic [1:0] sel [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
    int tickExp [4] = '{64, 32, 2, 8};
    logic [7:0] en [3] = '{8'h04, 8'h08, 8'h00};
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    rd(SCS_ADDR_CLKCTL);
    chk(rdv, 8'h00);
    rd(SCS_ADDR_STBYCTL);
    chk(rdv, 8'h00);
    rd(SCS_ADDR_STATUS);
    chk(rdv, 8'h00);
    chk({7'h00, mainOscRun_ff}, 8'h01);
    rd(4'hF);
    chk(rdv, 8'h00);
    // Every source in turn; a window of 128 clocks holds 64 main cycles
    for (int s = 0; s < 4; s++)
    begin
      wr(SCS_ADDR_CLKCTL, {6'h00, sel[s]});
      repeat (2) @(posedge clk_sys);
      for (i = 0; i < 140 && switchBusy_ff !== 1'b0; i++) @(posedge clk_sys);
      chk(8'(i < 140), 8'h01);
      rd(SCS_ADDR_STATUS);
      chk(rdv & 8'h03, {6'h00, sel[s]});
      ticks = 0;
      repeat (128) @(posedge clk_sys);
      chk(8'(ticks >= tickExp[s] - 1 && ticks <= tickExp[s] + 1), 8'h01);
    end
    // Stop main only with the sub clock already in use and settled
    wr(SCS_ADDR_CLKCTL, 8'h07);
    repeat (2) @(posedge clk_sys);
    chk({7'h00, mainOscRun_ff}, 8'h00);
    rd(SCS_ADDR_CLKCTL);
    chk(rdv, 8'h07);
    wr(SCS_ADDR_CLKCTL, 8'h03);
    repeat (2) @(posedge clk_sys);
    chk({7'h00, mainOscRun_ff}, 8'h01);
    standbyInhibit <= 1'b1;
    run_op(SCS_OP_STANDBY, 3);
    chk({7'h00, coreStall_ff}, 8'h00);
    standbyInhibit <= 1'b0;
    // Halt woken by pin, interrupt and overflow; disabled sources first
    for (int w = 0; w < 3; w++)
    begin
      wr(SCS_ADDR_STBYCTL, en[w]);
      run_op(SCS_OP_STANDBY, 3);
      rd(SCS_ADDR_STATUS);
      chk(rdv & 8'h30, 8'h10);
      wake_pin <= (w != 0);
      irqRelease <= (w != 1);
      repeat (6) @(posedge clk_sys);
      wake_pin <= 1'b0;
      irqRelease <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk({7'h00, haltActive_ff}, 8'h01);
      wake_pin <= (w == 0);
      irqRelease <= (w == 1);
      timeBaseOvf <= (w == 2);
      @(posedge clk_sys);
      timeBaseOvf <= 1'b0;
      for (i = 0; i < 8 && haltActive_ff !== 1'b0; i++) @(posedge clk_sys);
      chk(8'(i < 8), 8'h01);
      wake_pin <= 1'b0;
      irqRelease <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    // Pending time base flag: halt is entered, its overflow exit resets the watchdog
    tbReq <= 1'b1;
    wdFit <= 1'b1;
    wdSeen = 1'b0;
    run_op(SCS_OP_STANDBY, 3);
    chk({6'h00, wdSeen, haltActive_ff}, 8'h01);
    timeBaseOvf <= 1'b1;
    @(posedge clk_sys);
    timeBaseOvf <= 1'b0;
    repeat (3) @(posedge clk_sys);
    #1 chk({6'h00, wdSeen, haltActive_ff}, 8'h02);
    tbReq <= 1'b0;
    // Hold ignores everything but an enabled pin
    wr(SCS_ADDR_STBYCTL, 8'h01);
    clrSeen = 1'b0;
    run_op(8'h00, 0);
    run_op(SCS_OP_STANDBY, 3);
    chk({6'h00, clrSeen, holdActive_ff}, 8'h03);
    wake_pin <= 1'b1;
    irqRelease <= 1'b1;
    timeBaseOvf <= 1'b1;
    @(posedge clk_sys);
    timeBaseOvf <= 1'b0;
    repeat (6) @(posedge clk_sys);
    #1 chk({7'h00, holdActive_ff}, 8'h01);
    wr(SCS_ADDR_STBYCTL, 8'h03);
    for (i = 0; i < 8 && holdActive_ff !== 1'b0; i++) @(posedge clk_sys);
    chk(8'(i < 8), 8'h01);
    conclude();
  end
endmodule
